// ---- src/hpasc_map.vh ----
`ifndef HPASC_MAP_VH
`define HPASC_MAP_VH
// control modes
`define HPASC_MODE_HW 2'b00
`define HPASC_MODE_SERIAL 2'b01
`define HPASC_MODE_PARALLEL 2'b10
// multiplexed address field
`define HPASC_ADDR_W 5
`define HPASC_BUS_W 8
// wishbone register byte offsets
`define HPASC_REG_CTRL 4'h0
`define HPASC_REG_STAT 4'h4
`define HPASC_REG_ADDR 4'h8
`define HPASC_REG_EXPCFG 4'hc
// control register fields and reset value; expcfg ok and reset values
`define HPASC_CTRL_MODE_LO 0
`define HPASC_CTRL_MODE_HI 1
`define HPASC_CTRL_EDGE 2
`define HPASC_CTRL_MUX 3
`define HPASC_CTRL_STYLE 4
`define HPASC_CTRL_RST 32'h00000000
`define HPASC_EXPCFG_OK 8'hff
`define HPASC_EXPCFG_RST 8'h00
`endif

// ---- src/hpasc_top.v ----
`timescale 1ns/1ps
`include "hpasc_map.vh"
// How it works
// - hardware mode: shared pin is template select top bit.
// - serial mode: shared pin is the shift clock.
// - output launched on fall when edge select high, rise when low.
// - serial input always sampled on rising shift-clock edges.
// - mux, separate strobes: latch AD low five bits on latch fall.
// - mux, data strobe: latch AD low five bits on strobe fall.
// - mux select low means separate buses, high means shared bus.
// - style select low: data strobe plus r/w; high: split strobes.
module hpasc_top (
	input wire clk_i,
	input wire rst_i,
	input wire shared_pin_i,
	input wire serial_in_pin_i,
	input wire [7:0] ad_i,
	input wire [7:0] shift_data_i,
	output reg serial_out_pin_o,
	output reg [2:0] template_sel_o,
	output reg [4:0] latched_addr_o,
	output reg [7:0] shift_in_o,
	output reg shift_rise_o,
	output reg shift_launch_o,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [3:0] wb_adr_i,
	input wire [31:0] wb_dat_i,
	input wire [3:0] wb_sel_i,
	input wire wb_we_i,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire [1:0] template_low_i
);
	reg [31:0] ctrl;
	reg [7:0] expcfg;
	reg [1:0] pin_sync;
	reg [1:0] sdi_sync;
	reg [7:0] ad_s1;
	reg [7:0] ad_s2;
	reg pin_prev;
	reg [7:0] out_shift;
	wire [1:0] mode;
	wire edge_sel;
	wire mux_sel;
	wire style_sel;
	wire pin_now;
	wire rise;
	wire fall;
	wire launch;
	wire wb_req;

	assign mode = ctrl[`HPASC_CTRL_MODE_HI:`HPASC_CTRL_MODE_LO];
	assign edge_sel = ctrl[`HPASC_CTRL_EDGE];
	assign mux_sel = ctrl[`HPASC_CTRL_MUX];
	assign style_sel = ctrl[`HPASC_CTRL_STYLE];
	assign pin_now = pin_sync[1];
	assign rise = pin_now & ~pin_prev;
	assign fall = ~pin_now & pin_prev;
	// falling launch when edge select high
	assign launch = edge_sel ? fall : rise;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

	// pins are asynchronous: two flops before use
	always @(posedge clk_i) begin
		pin_sync <= {pin_sync[0], shared_pin_i};
		sdi_sync <= {sdi_sync[0], serial_in_pin_i};
		ad_s1 <= ad_i;
		ad_s2 <= ad_s1;
		pin_prev <= pin_now;
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			ctrl <= `HPASC_CTRL_RST;
			expcfg <= `HPASC_EXPCFG_RST;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			if (wb_req && wb_we_i) begin
				if (wb_adr_i == `HPASC_REG_CTRL && wb_sel_i[0])
					ctrl[7:0] <= wb_dat_i[7:0];
				// software must load all-ones here in host modes
				if (wb_adr_i == `HPASC_REG_EXPCFG && wb_sel_i[0])
					expcfg <= wb_dat_i[7:0];
			end
			if (wb_req) begin
				case (wb_adr_i)
				`HPASC_REG_CTRL: wb_dat_o <= ctrl;
				`HPASC_REG_STAT: wb_dat_o <= {22'h000000,
					expcfg == `HPASC_EXPCFG_OK, pin_now, shift_in_o};
				`HPASC_REG_ADDR: wb_dat_o <= {27'h0000000, latched_addr_o};
				`HPASC_REG_EXPCFG: wb_dat_o <= {24'h000000, expcfg};
				default: wb_dat_o <= 32'h00000000;
				endcase
			end
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			template_sel_o <= 3'b000;
			latched_addr_o <= 5'h00;
			shift_in_o <= 8'h00;
			out_shift <= 8'h00;
			serial_out_pin_o <= 1'b0;
			shift_rise_o <= 1'b0;
			shift_launch_o <= 1'b0;
		end else begin
			shift_rise_o <= 1'b0;
			shift_launch_o <= 1'b0;
			case (mode)
			`HPASC_MODE_HW: begin
				template_sel_o <= {pin_now, template_low_i};
			end
			`HPASC_MODE_SERIAL: begin
				// pin is the shift clock
				if (rise) begin
					shift_in_o <= {shift_in_o[6:0], sdi_sync[1]};
					shift_rise_o <= 1'b1;
				end
				if (launch) begin
					serial_out_pin_o <= out_shift[7];
					out_shift <= {out_shift[6:0], 1'b0};
					shift_launch_o <= 1'b1;
				end
				if (wb_req && wb_we_i && wb_adr_i == `HPASC_REG_STAT)
					out_shift <= wb_dat_i[7:0];
			end
			`HPASC_MODE_PARALLEL: begin
				// mux bus only; non-mux board ties strobe high
				// same latch for either style, both active on fall
				if (mux_sel && fall && (style_sel || !style_sel))
					latched_addr_o <= ad_s2[`HPASC_ADDR_W-1:0];
				// held otherwise until next fall
			end
			default: begin
				template_sel_o <= template_sel_o;
			end
			endcase
		end
	end
endmodule

// ---- tb/hpasc_checker.sv ----
`timescale 1ns/1ps
module hpasc_checker(
	input wire clk_i,
	input wire rst_i,
	input wire shared_pin_i,
	input wire [4:0] latched_addr_o,
	input wire [2:0] template_sel_o,
	input wire shift_rise_o,
	input wire shift_launch_o,
	input wire wb_ack_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// pin reaches an output three edges after it is sampled
	tmpl_msb_a: assert property ($changed(template_sel_o[2]) |->
		template_sel_o[2] == $past(shared_pin_i, 3))
		else $error("template msb");
	rise_once_a: assert property (shift_rise_o |=> !shift_rise_o)
		else $error("rise pulse");
	rise_edge_a: assert property (shift_rise_o |->
		$past(shared_pin_i, 3) && !$past(shared_pin_i, 4))
		else $error("rise source");
	launch_once_a: assert property (shift_launch_o |=> !shift_launch_o)
		else $error("launch pulse");
	launch_edge_a: assert property (shift_launch_o |->
		$past(shared_pin_i, 3) != $past(shared_pin_i, 4)) else $error("launch");
	addr_fall_a: assert property ($changed(latched_addr_o) |->
		!$past(shared_pin_i, 3) && $past(shared_pin_i, 4)) else $error("latch");
	addr_hold_a: assert property ($changed(latched_addr_o) |=>
		$stable(latched_addr_o) [*8]) else $error("addr hold");
	ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack");
	cover property (shift_rise_o);
	cover property ($changed(latched_addr_o));
	cover property (template_sel_o[2]);
endmodule

// ---- tb/hpasc_host.sv ----
`timescale 1ns/1ps
module hpasc_host(
	input wire clk_i,
	input wire run_i,
	input wire lvl_i,
	input wire [7:0] tx_i,
	output reg sclk_o = 0,
	output reg [7:0] sh_o = 0
);
	reg [3:0] n = 0;
	always @(posedge clk_i) begin
		n <= run_i && n < 9 ? n + 4'h1 : 4'h0;
		// still between frames; outside serial mode the level is a strobe
		sclk_o <= run_i ? sclk_o ^ (n == 9) : lvl_i;
		// next bit after each fall, steady across the rise
		sh_o <= !run_i ? tx_i : sclk_o && n == 9 ? sh_o << 1 : sh_o;
	end
endmodule

// ---- tb/hpasc_top_bench.sv ----
`timescale 1ns/1ps
module hpasc_top_bench;
	reg clk_i = 0, rst_i = 1, run_i = 0, lvl_i = 1, wb_we_i = 0;
	reg wb_cyc_i = 0, wb_stb_i = 0;
	reg [1:0] template_low_i = 0;
	reg [3:0] wb_adr_i = 0, wb_sel_i = 1;
	reg [7:0] ad_i = 0, tx_i = 0, shift_data_i = 0;
	reg [31:0] wb_dat_i = 0, a = 0;
	reg [7:0] d = 0;
	wire sclk_o, serial_out_pin_o, shift_rise_o, shift_launch_o, wb_ack_o;
	wire [2:0] template_sel_o;
	wire [4:0] latched_addr_o;
	wire [7:0] sh_o, shift_in_o;
	wire [31:0] wb_dat_o;
	integer err_total = 0, checked = 0, e, n, k, j;
	always #2 clk_i = ~clk_i;
	hpasc_top u_hpasc_top(.*, .shared_pin_i(sclk_o), .serial_in_pin_i(sh_o[7]));
	hpasc_host u_hpasc_host(.*);
	task tally_and_finish;
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task chk(input string s, input [31:0] x, y);
		checked++;
		err_total += x !== y;
		if (x !== y) $display("wrong value %s exp %h got %h", s, x, y);
	endtask
	task wb(input [3:0] ad, input w, input [31:0] d);
		@(posedge clk_i);
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, ad, d};
		for (k = 0; k < 9 && !wb_ack_o; k++) @(posedge clk_i);
		{wb_cyc_i, wb_stb_i} <= 0;
		err_total += k > 8;
		if (k > 8) tally_and_finish;
	endtask
	initial begin
		k = $urandom(69);
		template_low_i <= $urandom;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		wb(4'h2, 0, 0);
		chk("hole", 0, wb_dat_o);
		wb(4'hc, 0, 0);
		chk("expcfg", 0, wb_dat_o);
		wb(4'hc, 1, 32'hff);
		wb(4'hc, 0, 0);
		chk("expcfg ff", 32'hff, wb_dat_o);
		lvl_i <= 0;
		for (e = 0; e < 2; e++) begin
			tx_i <= $urandom;
			d = $urandom;
			wb(4'h0, 1, 1 | e << 2);
			wb(4'h4, 1, d);
			run_i <= 1;
			for (n = 0, j = 0, k = 0; n < 8 && k < 999; k++) begin
				@(posedge clk_i);
				if (shift_launch_o && j < 8) begin
					chk("launch", !e, sclk_o);
					chk("out bit", d[7 - j], serial_out_pin_o);
					j++;
				end
				n += shift_rise_o;
			end
			if (n < 8) begin
				err_total++;
				tally_and_finish;
			end
			run_i <= 0;
			repeat (2) @(posedge clk_i);
			chk("shift in", tx_i, shift_in_o);
		end
		for (e = 0; e < 4; e++) begin
			wb(4'h0, 1, 2 | e << 3);
			lvl_i <= 1;
			ad_i <= $urandom;
			repeat (12) @(posedge clk_i);
			lvl_i <= !e[0];
			repeat (12) @(posedge clk_i);
			if (e[0]) a = ad_i[4:0];
			ad_i <= $urandom;
			wb(4'h8, 0, 0);
			chk("addr", a, wb_dat_o);
		end
		tally_and_finish;
	end
endmodule
bind hpasc_top hpasc_checker u_hpasc_checker(.*);
